// >>> hdl/acc_i2c_eng.sv
// Two-wire target engine, clocked by SCL itself.
// Assumes the SCL and SDA pins arrive raw; reset is asynchronous and active low.
module acc_i2c_eng #(
    parameter logic [6:0] TGT_ADDR = acc_pkg::TARGET_ADDR
) (
    // Link pins
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_oe,
    // Reset
    input wire logic rst_n,
    // Core side
    acc_link_if.eng lk
);

    typedef struct packed {
        acc_pkg::acc_eng_state_t st;
        logic [3:0] bit_cnt;
        logic [7:0] shreg;
        logic [1:0] byte_cnt;
        logic start_seen;
        logic pub_s1;
        logic pub_s2;
        logic pub_ack;
        logic [23:0] snap;
        logic [7:0] wr_data;
        logic wr_tgl;
        logic rd_tgl;
    } acc_eng_reg_t;

    acc_eng_reg_t r;
    acc_eng_reg_t n;
    logic start_tgl;
    logic [7:0] tx_byte;
    logic next_oe;

    // ----------------------------------------
    // Start detection
    // ----------------------------------------
    // SDA falling while SCL high; stable long before the next SCL rise
    always_ff @(negedge sda_in or negedge rst_n) begin
        if (!rst_n) begin
            start_tgl <= 1'b0;
        end else if (scl) begin
            start_tgl <= ~start_tgl;
        end
    end

    // ----------------------------------------
    // Receive side, rising SCL
    // ----------------------------------------
    always_comb begin
        n = r;
        n.pub_s1 = lk.pub_tgl;
        n.pub_s2 = r.pub_s1;
        // Snapshot frozen for the whole read so flag matches data
        if (r.pub_s2 != r.pub_ack && r.st != acc_pkg::ENG_READ) begin
            n.snap = lk.pub_data;
            n.pub_ack = r.pub_s2;
        end
        if (start_tgl != r.start_seen) begin
            n.start_seen = start_tgl;
            n.st = acc_pkg::ENG_ADDR;
            n.shreg = {r.shreg[6:0], sda_in};
            n.bit_cnt = 4'h1;
        end else if (r.bit_cnt != acc_pkg::ACK_SLOT) begin
            n.shreg = {r.shreg[6:0], sda_in};
            n.bit_cnt = r.bit_cnt + 4'h1;
            if (r.st == acc_pkg::ENG_READ && r.byte_cnt == acc_pkg::CFG_BYTE && r.bit_cnt == 4'h0) begin
                n.rd_tgl = ~r.rd_tgl;
            end
        end else begin
            n.bit_cnt = 4'h0;
            unique case (r.st)
                acc_pkg::ENG_IDLE: begin
                    n.st = acc_pkg::ENG_IDLE;
                end
                acc_pkg::ENG_ADDR: begin
                    n.byte_cnt = 2'h0;
                    if (r.shreg[7:1] == TGT_ADDR) begin
                        n.st = r.shreg[0] ? acc_pkg::ENG_READ : acc_pkg::ENG_WRITE;
                    end else begin
                        n.st = acc_pkg::ENG_IDLE;
                    end
                end
                acc_pkg::ENG_WRITE: begin
                    if (r.byte_cnt == 2'h0) begin
                        n.wr_data = r.shreg;
                        n.wr_tgl = ~r.wr_tgl;
                        n.byte_cnt = 2'h1;
                    end
                end
                acc_pkg::ENG_READ: begin
                    if (sda_in) begin
                        n.st = acc_pkg::ENG_IDLE;
                    end else if (r.byte_cnt != acc_pkg::PAST_BYTE) begin
                        n.byte_cnt = r.byte_cnt + 2'h1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge scl or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // ----------------------------------------
    // Drive side, falling SCL
    // ----------------------------------------
    always_comb begin
        unique case (r.byte_cnt)
            2'h0: tx_byte = r.snap[23:16];
            2'h1: tx_byte = r.snap[15:8];
            2'h2: tx_byte = r.snap[7:0];
            2'h3: tx_byte = acc_pkg::FILL_BYTE;
        endcase
        next_oe = 1'b0;
        if (r.bit_cnt == acc_pkg::ACK_SLOT) begin
            if (r.st == acc_pkg::ENG_ADDR) begin
                next_oe = (r.shreg[7:1] == TGT_ADDR);
            end else if (r.st == acc_pkg::ENG_WRITE) begin
                next_oe = (r.byte_cnt == 2'h0);
            end
        end else if (r.st == acc_pkg::ENG_READ) begin
            next_oe = ~tx_byte[~r.bit_cnt[2:0]];
        end
    end

    always_ff @(negedge scl or negedge rst_n) begin
        if (!rst_n) begin
            sda_oe <= 1'b0;
        end else begin
            sda_oe <= next_oe;
        end
    end

    assign lk.pub_ack = r.pub_ack;
    assign lk.wr_data = r.wr_data;
    assign lk.wr_tgl = r.wr_tgl;
    assign lk.rd_tgl = r.rd_tgl;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_nack_extra;
        @(posedge scl) disable iff (!rst_n)
        r.st == acc_pkg::ENG_WRITE && r.bit_cnt == acc_pkg::ACK_SLOT && r.byte_cnt != 2'h0 |-> !sda_oe;
    endproperty
    a_nack_extra: assert property (p_nack_extra) else $error("extra write byte acknowledged");

    property p_fill;
        @(posedge scl) disable iff (!rst_n)
        r.st == acc_pkg::ENG_READ && r.byte_cnt == acc_pkg::PAST_BYTE && r.bit_cnt != acc_pkg::ACK_SLOT |-> !sda_oe;
    endproperty
    a_fill: assert property (p_fill) else $error("byte past config not all ones");

    property p_first_byte;
        @(posedge scl) disable iff (!rst_n)
        r.st == acc_pkg::ENG_READ && r.byte_cnt == 2'h0 && r.bit_cnt == 4'h0 |-> sda_oe == !r.snap[23];
    endproperty
    a_first_byte: assert property (p_first_byte) else $error("read does not open with result");

endmodule

// >>> hdl/acc_top.sv
// Converter control core: configuration, conversion timing, result hold.
// Assumes RESULT_DATA is produced on CLK; SCL and SDA come from the bus pins.
// How it works
// - Configuration comes up as 8C hex
// - Single mode: writing start bit starts conversion
// - Continuous mode ignores the written start bit
// - New result clears the fresh flag
// - Reading configuration byte sets the flag
// - Read flag is internal state, never written value
// - Zero means new data; one means old
// - Flag belongs to result bytes of same read
// - Bit four picks single or continuous mode
// - Rate field picks 240, 60, 30, 15 SPS
// - Gain field picks gain 1, 2, 4, 8
// - Single mode powers down after conversion
// - Read returns result bytes then configuration
// - Host may end a read early
// - Bytes past third read as FF
// - Result stays unchanged until next conversion
// - Write stores first byte; result not writable
// - Only first written byte is acknowledged
module acc_top #(
    parameter logic [6:0] TARGET_ADDR = acc_pkg::TARGET_ADDR,
    parameter int unsigned CONV_CYC0 = acc_pkg::CONV_CYC0,
    parameter int unsigned CONV_CYC1 = acc_pkg::CONV_CYC1,
    parameter int unsigned CONV_CYC2 = acc_pkg::CONV_CYC2,
    parameter int unsigned CONV_CYC3 = acc_pkg::CONV_CYC3
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // Two-wire link
    input wire logic SCL,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    // Converter core
    input wire logic [15:0] RESULT_DATA,
    output logic [1:0] RATE_SEL,
    output logic [1:0] GAIN_SEL,
    output logic POWER_DOWN,
    output logic RESULT_LOAD
);

    typedef struct packed {
        logic single;
        logic [1:0] rate;
        logic [1:0] gain;
        logic flag;
        logic [15:0] result;
        logic [23:0] cnt;
        logic conv_run;
        logic pdn;
        logic load;
        logic wr_s1;
        logic wr_s2;
        logic wr_seen;
        logic rd_s1;
        logic rd_s2;
        logic rd_seen;
        logic ack_s1;
        logic ack_s2;
        logic [23:0] pub;
        logic pub_tgl;
        logic sda_out;
    } acc_ctl_reg_t;

    // Continuous mode from reset, so the converter runs at once
    localparam acc_ctl_reg_t RST = '{
        single: acc_pkg::CFG_RESET[acc_pkg::SINGLE_BIT],
        rate: acc_pkg::CFG_RESET[acc_pkg::RATE_HI:acc_pkg::RATE_LO],
        gain: acc_pkg::CFG_RESET[acc_pkg::GAIN_HI:acc_pkg::GAIN_LO],
        flag: acc_pkg::CFG_RESET[acc_pkg::FLAG_BIT],
        conv_run: 1'b1,
        default: '0
    };

    acc_ctl_reg_t r;
    acc_ctl_reg_t n;
    logic wr_evt;
    logic rd_evt;
    logic conv_end;
    logic [23:0] per;
    logic [23:0] cur;

    acc_link_if lk ();

    // ----------------------------------------
    // Link engine
    // ----------------------------------------
    acc_i2c_eng #(
        .TGT_ADDR(TARGET_ADDR)
    ) u_eng (
        .scl(SCL),
        .sda_in(SDA_IN),
        .sda_oe(SDA_OE),
        .rst_n(RESET_N),
        .lk(lk)
    );

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        n = r;
        n.load = 1'b0;
        n.wr_s1 = lk.wr_tgl;
        n.wr_s2 = r.wr_s1;
        n.rd_s1 = lk.rd_tgl;
        n.rd_s2 = r.rd_s1;
        n.ack_s1 = lk.pub_ack;
        n.ack_s2 = r.ack_s1;
        wr_evt = (r.wr_s2 != r.wr_seen);
        rd_evt = (r.rd_s2 != r.rd_seen);
        unique case (r.rate)
            2'b00: per = 24'(CONV_CYC0);
            2'b01: per = 24'(CONV_CYC1);
            2'b10: per = 24'(CONV_CYC2);
            2'b11: per = 24'(CONV_CYC3);
        endcase
        conv_end = r.conv_run && (r.cnt >= per - 24'h00_0001);
        if (r.conv_run) begin
            n.cnt = r.cnt + 24'h00_0001;
        end
        // Conversion wins over a read in the same cycle: new data is kept
        if (rd_evt) begin
            n.rd_seen = r.rd_s2;
            n.flag = 1'b1;
        end
        if (conv_end) begin
            n.result = RESULT_DATA;
            n.load = 1'b1;
            n.flag = 1'b0;
            n.cnt = 24'h00_0000;
            if (r.single) begin
                n.conv_run = 1'b0;
                n.pdn = 1'b1;
            end
        end
        // Written flag bit is only a command, never stored
        if (wr_evt) begin
            n.wr_seen = r.wr_s2;
            n.single = lk.wr_data[acc_pkg::SINGLE_BIT];
            n.rate = lk.wr_data[acc_pkg::RATE_HI:acc_pkg::RATE_LO];
            n.gain = lk.wr_data[acc_pkg::GAIN_HI:acc_pkg::GAIN_LO];
            if (!lk.wr_data[acc_pkg::SINGLE_BIT]) begin
                n.conv_run = 1'b1;
                n.pdn = 1'b0;
            end else if (lk.wr_data[acc_pkg::FLAG_BIT]) begin
                n.conv_run = 1'b1;
                n.pdn = 1'b0;
                n.cnt = 24'h00_0000;
            end
        end
        // Reserved bits always read back as zero
        cur = {r.result, r.flag, 2'b00, r.single, r.rate, r.gain};
        // One word in flight at a time; the engine keeps the last acknowledged one
        if (r.ack_s2 == r.pub_tgl && r.pub != cur) begin
            n.pub = cur;
            n.pub_tgl = ~r.pub_tgl;
        end
        n.sda_out = 1'b0;
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            r <= RST;
        end else begin
            r <= n;
        end
    end

    assign lk.pub_data = r.pub;
    assign lk.pub_tgl = r.pub_tgl;
    assign SDA_OUT = r.sda_out;
    assign RATE_SEL = r.rate;
    assign GAIN_SEL = r.gain;
    assign POWER_DOWN = r.pdn;
    assign RESULT_LOAD = r.load;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    logic init_done;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            init_done <= 1'b0;
        end else begin
            init_done <= 1'b1;
        end
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);

    property p_cfg_reset;
        !init_done |-> ({r.flag, 2'b00, r.single, r.rate, r.gain} == acc_pkg::CFG_RESET) && r.conv_run;
    endproperty
    a_cfg_reset: assert property (p_cfg_reset) else $error("configuration not at reset value");

    property p_start;
        wr_evt && lk.wr_data[acc_pkg::SINGLE_BIT] && lk.wr_data[acc_pkg::FLAG_BIT]
            |=> r.conv_run && !r.pdn && r.cnt == 24'h00_0000 ##1 r.cnt == 24'h00_0001;
    endproperty
    a_start: assert property (p_start) else $error("single start did not begin conversion");

    property p_cont_run;
        !r.single |-> r.conv_run && !r.pdn;
    endproperty
    a_cont_run: assert property (p_cont_run) else $error("continuous mode stopped");

    property p_load;
        conv_end |=> r.load && !r.flag && r.result == $past(RESULT_DATA);
    endproperty
    a_load: assert property (p_load) else $error("result load did not clear flag");

    property p_read_set;
        rd_evt && !conv_end |=> r.flag;
    endproperty
    a_read_set: assert property (p_read_set) else $error("config read did not set flag");

    property p_flag_write;
        wr_evt && !conv_end && !rd_evt |=> r.flag == $past(r.flag);
    endproperty
    a_flag_write: assert property (p_flag_write) else $error("write changed the flag");

    property p_pdn;
        conv_end && r.single && !wr_evt |=> r.pdn && !r.conv_run ##1 POWER_DOWN;
    endproperty
    a_pdn: assert property (p_pdn) else $error("no power-down after single conversion");

    property p_hold;
        !conv_end |=> $stable(r.result) && !r.load;
    endproperty
    a_hold: assert property (p_hold) else $error("result changed without conversion");

    property p_pub;
        $changed(r.pub) |-> $past(r.ack_s2 == r.pub_tgl) && $changed(r.pub_tgl);
    endproperty
    a_pub: assert property (p_pub) else $error("published word changed while in flight");

    // ----------------------------------------
    // Field, flag and power checks
    // ----------------------------------------
    property p_no_start;
        wr_evt && r.pdn && lk.wr_data[acc_pkg::SINGLE_BIT] && !lk.wr_data[acc_pkg::FLAG_BIT] |=> r.pdn && !r.conv_run;
    endproperty
    a_no_start: assert property (p_no_start) else $error("zero start bit began a conversion");

    property p_cont_next;
        conv_end && !r.single && !wr_evt |=> r.conv_run && r.cnt == 24'h00_0000;
    endproperty
    a_cont_next: assert property (p_cont_next) else $error("continuous mode did not restart");

    property p_flag_cause;
        $changed(r.flag) |-> $past(conv_end || rd_evt);
    endproperty
    a_flag_cause: assert property (p_flag_cause) else $error("flag moved without load or read");

    property p_mode_hold;
        $changed(r.single) |-> $past(wr_evt);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed without write");

    property p_rate_hold;
        $changed(r.rate) |-> $past(wr_evt);
    endproperty
    a_rate_hold: assert property (p_rate_hold) else $error("rate changed without write");

    property p_gain_hold;
        $changed(r.gain) |-> $past(wr_evt);
    endproperty
    a_gain_hold: assert property (p_gain_hold) else $error("gain changed without write");

    property p_pdn_cause;
        $rose(r.pdn) |-> $past(conv_end && r.single);
    endproperty
    a_pdn_cause: assert property (p_pdn_cause) else $error("power-down without finished single");

    property p_idle_cnt;
        r.pdn && !wr_evt |=> r.pdn && $stable(r.cnt);
    endproperty
    a_idle_cnt: assert property (p_idle_cnt) else $error("timer ran while powered down");

    property p_wr_fields;
        wr_evt |=> r.single == $past(lk.wr_data[acc_pkg::SINGLE_BIT])
            && r.rate == $past(lk.wr_data[acc_pkg::RATE_HI:acc_pkg::RATE_LO])
            && r.gain == $past(lk.wr_data[acc_pkg::GAIN_HI:acc_pkg::GAIN_LO]);
    endproperty
    a_wr_fields: assert property (p_wr_fields) else $error("written byte not stored");

    property p_load_pulse;
        r.load |=> !r.load;
    endproperty
    a_load_pulse: assert property (p_load_pulse) else $error("result load longer than one cycle");

    c_single: cover property (wr_evt && lk.wr_data[acc_pkg::SINGLE_BIT] && lk.wr_data[acc_pkg::FLAG_BIT]);
    c_read: cover property (rd_evt);
    c_pdn: cover property ($rose(r.pdn));
    c_cont_load: cover property (conv_end && !r.single);
    c_start_ignored: cover property (wr_evt && !lk.wr_data[acc_pkg::SINGLE_BIT] && lk.wr_data[acc_pkg::FLAG_BIT]);

endmodule

// >>> inc/acc_link_if.sv
// Signals between the control core and the link engine.
// Toggles carry events; words next to them stay stable until the toggle is seen.
interface acc_link_if;
    logic [23:0] pub_data;
    logic pub_tgl;
    logic pub_ack;
    logic [7:0] wr_data;
    logic wr_tgl;
    logic rd_tgl;

    modport ctl (output pub_data, output pub_tgl, input pub_ack, input wr_data, input wr_tgl, input rd_tgl);
    modport eng (input pub_data, input pub_tgl, output pub_ack, output wr_data, output wr_tgl, output rd_tgl);
endinterface

// >>> inc/acc_pkg.sv
// Constants and types shared by the converter control block.
// Assumes a single 125 MHz system clock and an SCL-clocked link side.
package acc_pkg;

    // ----------------------------------------
    // Configuration byte layout
    // ----------------------------------------
    localparam logic [7:0] CFG_RESET = 8'h8C;
    localparam int FLAG_BIT = 7;
    localparam int SINGLE_BIT = 4;
    localparam int RATE_HI = 3;
    localparam int RATE_LO = 2;
    localparam int GAIN_HI = 1;
    localparam int GAIN_LO = 0;

    // ----------------------------------------
    // Link framing
    // ----------------------------------------
    localparam logic [6:0] TARGET_ADDR = 7'h48;
    localparam logic [7:0] FILL_BYTE = 8'hFF;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [1:0] CFG_BYTE = 2'h2;
    localparam logic [1:0] PAST_BYTE = 2'h3;

    // ----------------------------------------
    // Conversion timing
    // ----------------------------------------
    localparam int unsigned CLK_HZ = 32'h0773_5940;
    localparam int unsigned RATE0_SPS = 32'h0000_00F0;
    localparam int unsigned RATE1_SPS = 32'h0000_003C;
    localparam int unsigned RATE2_SPS = 32'h0000_001E;
    localparam int unsigned RATE3_SPS = 32'h0000_000F;
    localparam int unsigned CONV_CYC0 = CLK_HZ / RATE0_SPS;
    localparam int unsigned CONV_CYC1 = CLK_HZ / RATE1_SPS;
    localparam int unsigned CONV_CYC2 = CLK_HZ / RATE2_SPS;
    localparam int unsigned CONV_CYC3 = CLK_HZ / RATE3_SPS;

    typedef enum logic [1:0] {
        ENG_IDLE = 2'b00,
        ENG_ADDR = 2'b01,
        ENG_WRITE = 2'b10,
        ENG_READ = 2'b11
    } acc_eng_state_t;

endpackage

// >>> verif/acc_host_model.sv
// Two-wire bus controller model facing the converter control block.
// Assumes the bench resolves SDA with a pull-up; SCL stands high between frames.
module acc_host_model (
    // Link pins
    output logic scl,
    output logic sda_oe,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // Bit timing
    // ----------------------------------------
    // Quarter of the 125 ns link clock period
    localparam realtime Q = 31.25;

    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end

    // Also serves as repeated start: SDA released while SCL is low
    task automatic start();
        sda_oe = 1'b0;
        #Q scl = 1'b1;
        #Q sda_oe = 1'b1;
        #Q scl = 1'b0;
        #Q;
    endtask

    // Gap after stop covers the config publish into the core
    task automatic stop();
        sda_oe = 1'b1;
        #Q scl = 1'b1;
        #Q sda_oe = 1'b0;
        #(8 * Q);
    endtask

    // SDA changes only while SCL is low
    task automatic bit_io(input logic b, output logic r);
        sda_oe = ~b;
        #Q scl = 1'b1;
        #Q r = sda;
        #Q scl = 1'b0;
        #Q;
    endtask

    // Ninth bit high releases SDA; on a read it ends the transfer early
    task automatic xfer(input logic [7:0] d, input logic nine, output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(nine, r);
        ack = ~r;
    endtask
endmodule

// >>> verif/adc_i2c_config_readout_test.sv
// Self-checking bench for the converter control block.
// Assumes acc_top and the bus controller model; conversion counts are shortened.
module adc_i2c_config_readout_test;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [6:0] TA = acc_pkg::TARGET_ADDR;
    logic clk;
    logic reset_n;
    logic [15:0] result_data;
    logic scl, h_oe, sda_oe, sda_out, power_down, result_load, ack;
    logic [1:0] rate_sel, gain_sel;
    logic sda;
    logic [7:0] b [4];
    int n_errors, n_checks, n_loads, since_load, gap, low_cnt;

    // ----------------------------------------
    // Clock, wire and instances
    // ----------------------------------------
    initial clk = 1'b0;
    always #4 clk = ~clk;
    // Pull-up wins unless a party pulls low
    assign sda = (h_oe | (sda_oe & ~sda_out)) ? 1'b0 : 1'b1;

    acc_top #(.CONV_CYC0(600), .CONV_CYC1(1200), .CONV_CYC2(1800), .CONV_CYC3(2400)) dut (
        .CLK(clk), .RESET_N(reset_n), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
        .RESULT_DATA(result_data), .RATE_SEL(rate_sel), .GAIN_SEL(gain_sel),
        .POWER_DOWN(power_down), .RESULT_LOAD(result_load));
    acc_host_model host (.scl(scl), .sda_oe(h_oe), .sda(sda));

    always @(posedge clk) begin
        if (result_load === 1'b1) begin
            gap = since_load;
            since_load = 0;
            n_loads++;
        end else begin
            since_load++;
        end
        if (power_down === 1'b0) begin
            low_cnt++;
        end
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results();
        $display("Checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] q;
        host.start();
        host.xfer({a, 1'b0}, 1'b1, q, ack);
        if (ack) begin
            host.xfer(d, 1'b1, q, ack);
        end
        host.stop();
    endtask

    task automatic rd(input int n);
        logic [7:0] q;
        logic a;
        host.start();
        host.xfer({TA, 1'b1}, 1'b1, q, a);
        for (int i = 0; i < n; i++) begin
            host.xfer(8'hFF, i == n - 1, b[i], a);
        end
        host.stop();
    endtask

    task automatic wait_pd(input logic lvl);
        int c;
        c = 0;
        while (power_down !== lvl && c < 4000) begin
            @(posedge clk);
            c++;
        end
        check("power_down", 16'(power_down), 16'(lvl));
    endtask

    task automatic wait_load();
        int l, c;
        l = n_loads;
        c = 0;
        while (n_loads == l && c < 3000) begin
            @(posedge clk);
            c++;
        end
        check("load_seen", 16'(n_loads != l), 16'h0001);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        check("rate_sel", 16'(rate_sel), 16'h0003);
        check("gain_sel", 16'(gain_sel), 16'h0000);
        rd(4);
        check("cfg", 16'(b[2]), 16'h008C);
        check("past_third", 16'(b[3]), 16'h00FF);
    endtask

    // Reserved bits always written as zero
    task automatic t_single();
        @(posedge clk) result_data <= 16'hA53C;
        wr(TA, 8'h1F);
        wait_pd(1'b1);
        rd(3);
        check("result", {b[0], b[1]}, 16'hA53C);
        check("cfg", 16'(b[2]), 16'h001F);
        @(posedge clk) result_data <= 16'hBEEF;
        rd(3);
        check("result", {b[0], b[1]}, 16'hA53C);
        check("cfg", 16'(b[2]), 16'h009F);
    endtask

    task automatic t_fields();
        int l;
        logic [1:0] r;
        l = n_loads;
        for (int i = 0; i < 4; i++) begin
            r = i[1:0];
            wr(TA, {4'b0001, r, ~r});
            check("rate_sel", 16'(rate_sel), 16'(r));
            check("gain_sel", 16'(gain_sel), 16'(2'(~r)));
        end
        check("power_down", 16'(power_down), 16'h0001);
        check("loads", 16'(n_loads - l), 16'h0000);
        rd(3);
        check("cfg", 16'(b[2]), 16'h009C);
    endtask

    // Rate 00 gives the shortest period, seen as the power-up span
    task automatic t_start();
        @(posedge clk) result_data <= 16'h1234;
        low_cnt = 0;
        wr(TA, 8'h90);
        wait_pd(1'b1);
        check("busy_span", 16'(low_cnt >= 597 && low_cnt <= 603), 16'h0001);
        rd(2);
        check("result", {b[0], b[1]}, 16'h1234);
        rd(3);
        check("cfg", 16'(b[2]), 16'h0010);
    endtask

    // A restart would stretch the gap by the length of the write
    task automatic t_cont();
        wr(TA, 8'h00);
        wait_load();
        wr(TA, 8'h80);
        wait_load();
        check("gap", 16'(gap >= 595 && gap <= 605), 16'h0001);
        check("power_down", 16'(power_down), 16'h0000);
    endtask

    task automatic t_refuse();
        logic [7:0] q;
        wr(7'h49, 8'h1C);
        check("addr_ack", 16'(ack), 16'h0000);
        check("rate_sel", 16'(rate_sel), 16'h0000);
        host.start();
        host.xfer({TA, 1'b0}, 1'b1, q, ack);
        host.xfer(8'h1C, 1'b1, q, ack);
        check("first_ack", 16'(ack), 16'h0001);
        host.xfer(8'h03, 1'b1, q, ack);
        check("second_ack", 16'(ack), 16'h0000);
        host.stop();
        check("rate_sel", 16'(rate_sel), 16'h0003);
        check("gain_sel", 16'(gain_sel), 16'h0000);
    endtask

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        reset_n <= 1'b0;
        result_data <= 16'h0000;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        repeat (12) @(posedge clk);
        t_reset();
        t_single();
        t_fields();
        t_start();
        t_cont();
        t_refuse();
        results();
    end

    // Whole run needs well under half of this span
    initial begin
        repeat (40000) @(posedge clk);
        n_errors++;
        results();
    end
endmodule
